/* t1l_defines.svh */
`ifndef T1L_DEFINES_SVH
`define T1L_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define T1L_IDX_CTL_TWO 16'h0f02
`define T1L_IDX_CTL_THREE 16'h0f03
`define T1L_IDX_STATUS 16'h0f05
`define T1L_ADDR_W 16

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define T1L_DRIVER_ENABLE_PIN_BIT 3
`define T1L_LOOP_MSB 2
`define T1L_LOOP_LSB 0
`define T1L_NLCDE_MSB 7
`define T1L_NLCDE_LSB 6
`define T1L_FLAG_BIT 3
`define T1L_CTL_TWO_RST 4'h0
`define T1L_CTL_THREE_RST 2'h0

// ----------------------------------------------------------------
// Loop-back and detection encodings
// ----------------------------------------------------------------
`define T1L_LOOP_DUAL 3'h4
`define T1L_LOOP_ANALOG 3'h5
`define T1L_LOOP_REMOTE 3'h6
`define T1L_LOOP_DIGITAL 3'h7
`define T1L_DET_OFF 2'h0
`define T1L_DET_UP 2'h1
`define T1L_DET_DOWN 2'h2
`define T1L_DET_AUTO 2'h3

// ----------------------------------------------------------------
// Loop codes and sustain time
// ----------------------------------------------------------------
`define T1L_UP_PERIOD 5
`define T1L_DOWN_PERIOD 3
`define T1L_DETECT_TIME_S 5
`define T1L_LINE_RATE_BPS 1544000

`endif

/* t1l_pkg.sv */
package t1l_pkg;
    typedef enum logic [4:0] {
        T1L_ST_OFF = 5'h01,
        T1L_ST_UP = 5'h02,
        T1L_ST_DOWN = 5'h04,
        T1L_ST_AUTO_UP = 5'h08,
        T1L_ST_AUTO_LOOP = 5'h10
    } t1l_det_state_t;
endpackage : t1l_pkg

/* t1l_sync2.sv */
module t1l_sync2 #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : t1l_sync2

/* t1l_line_ctrl.sv */
// Design decision made here: the APB slave port.
`include "t1l_defines.svh"

module t1l_line_ctrl import t1l_pkg::*; #(
    parameter int DETECT_BITS = `T1L_DETECT_TIME_S * `T1L_LINE_RATE_BPS,
    parameter int CNT_W = 23
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic driver_enable_pin,
    input wire logic rx_line_data,
    input wire logic rx_line_clk,
    input wire logic tx_data,
    input wire logic tx_bit_stb,
    output logic line_tx_positive,
    output logic line_tx_positive_oe_n,
    output logic line_tx_negative,
    output logic line_tx_negative_oe_n,
    output logic rx_data,
    output logic rx_bit_stb,
    output logic loop_code_detected_flag
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pin_sync;
    logic pin_en_s;
    logic rx_d_s;
    logic rx_c_s;
    logic rx_c_prev_q;
    logic rx_stb;

    t1l_sync2 #(.W(3)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .async_in({driver_enable_pin, rx_line_data, rx_line_clk}),
        .sync_out(pin_sync)
    );
    assign pin_en_s = pin_sync[2];
    assign rx_d_s = pin_sync[1];
    assign rx_c_s = pin_sync[0];
    assign rx_stb = rx_c_s & ~rx_c_prev_q;

    // ----------------------------------------------------------------
    // APB register file
    // ----------------------------------------------------------------
    logic [3:0] ctl2_q;
    logic [1:0] nlcde_q;
    logic flag_q;
    logic [`T1L_ADDR_W-1:0] idx;
    logic hit_two;
    logic hit_three;
    logic hit_stat;
    logic mapped;
    logic wr_acc;
    logic [31:0] rd_mux;
    logic flag_clr;
    logic flag_set;

    assign idx = paddr[`T1L_ADDR_W+1:2];
    assign hit_two = (idx == `T1L_IDX_CTL_TWO);
    assign hit_three = (idx == `T1L_IDX_CTL_THREE);
    assign hit_stat = (idx == `T1L_IDX_STATUS);
    assign mapped = (paddr[1:0] == 2'h0) && (hit_two || hit_three || hit_stat)
        && (paddr[31:`T1L_ADDR_W+2] == '0);
    assign wr_acc = ce && psel && penable && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = rd_mux;
    // Status flag is write-one-to-clear
    assign flag_clr = wr_acc && hit_stat && pwdata[`T1L_FLAG_BIT];

    logic [31:0] rd_d;
    logic [31:0] rd_q;
    assign rd_d = !mapped ? 32'h0 :
        hit_two ? {28'h0, ctl2_q} :
        hit_three ? {24'h0, nlcde_q, 6'h0} :
        {28'h0, flag_q, 3'h0};
    assign rd_mux = rd_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl2_q <= `T1L_CTL_TWO_RST;
            nlcde_q <= `T1L_CTL_THREE_RST;
            rd_q <= 32'h0;
        end else if (ce) begin
            if (psel && !penable) begin
                rd_q <= rd_d;
            end
            if (wr_acc && hit_two) begin
                ctl2_q <= pwdata[3:0];
            end
            if (wr_acc && hit_three) begin
                nlcde_q <= pwdata[`T1L_NLCDE_MSB:`T1L_NLCDE_LSB];
            end
        end
    end

    // ----------------------------------------------------------------
    // Loop-code detection
    // ----------------------------------------------------------------
    t1l_det_state_t st_q;
    t1l_det_state_t st_d;
    logic [4:0] hist_q;
    logic [CNT_W-1:0] cnt_q;
    logic [4:0] win5;
    logic [2:0] win3;
    logic up_ok;
    logic down_ok;
    logic want_down;
    logic bit_ok;
    logic hit;
    logic armed;

    assign win5 = {hist_q[3:0], rx_d_s};
    assign win3 = {hist_q[1:0], rx_d_s};
    // Periodic with one mark per period picks out every phase of the code
    assign up_ok = (rx_d_s == hist_q[`T1L_UP_PERIOD-1]) && ($countones(win5) == 1);
    assign down_ok = (rx_d_s == hist_q[`T1L_DOWN_PERIOD-1]) && ($countones(win3) == 1);
    assign want_down = (st_q == T1L_ST_DOWN) || (st_q == T1L_ST_AUTO_LOOP);
    assign bit_ok = want_down ? down_ok : up_ok;
    assign armed = (st_q != T1L_ST_OFF);
    assign hit = armed && rx_stb && bit_ok && (cnt_q == CNT_W'(DETECT_BITS - 1));
    assign flag_set = hit && (st_q != T1L_ST_AUTO_LOOP);

    always_comb begin
        st_d = st_q;
        case (nlcde_q)
            `T1L_DET_OFF: st_d = T1L_ST_OFF;
            `T1L_DET_UP: st_d = T1L_ST_UP;
            `T1L_DET_DOWN: st_d = T1L_ST_DOWN;
            default: begin
                case (st_q)
                    T1L_ST_AUTO_UP: st_d = hit ? T1L_ST_AUTO_LOOP : T1L_ST_AUTO_UP;
                    T1L_ST_AUTO_LOOP: st_d = hit ? T1L_ST_AUTO_UP : T1L_ST_AUTO_LOOP;
                    default: st_d = T1L_ST_AUTO_UP;
                endcase
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= T1L_ST_OFF;
            hist_q <= 5'h00;
            cnt_q <= '0;
            rx_c_prev_q <= 1'b0;
            flag_q <= 1'b0;
        end else if (ce) begin
            rx_c_prev_q <= rx_c_s;
            st_q <= st_d;
            if (rx_stb) begin
                hist_q <= win5;
            end
            // Count restarts whenever the watched code changes
            if (st_d != st_q || !armed) begin
                cnt_q <= '0;
            end else if (rx_stb) begin
                if (!bit_ok || hit) begin
                    cnt_q <= '0;
                end else begin
                    cnt_q <= cnt_q + CNT_W'(1);
                end
            end
            // Set wins over a clear in the same cycle
            if (flag_set) begin
                flag_q <= 1'b1;
            end else if (flag_clr) begin
                flag_q <= 1'b0;
            end
        end
    end
    assign loop_code_detected_flag = flag_q;

    // ----------------------------------------------------------------
    // Retimed control and loop-back data path
    // ----------------------------------------------------------------
    logic drv_en_q;
    logic [2:0] loop_q;
    logic [2:0] mode;
    logic remote;
    logic digital;
    logic analog;
    logic src_bit;
    logic src_stb;
    logic pos_q;
    logic neg_q;
    logic alt_q;
    logic rx_q;
    logic rx_stb_q;

    // Auto loop-back overrides the select field from loop-up detection until the loop-down code is detected
    assign mode = (st_q == T1L_ST_AUTO_LOOP) ? `T1L_LOOP_REMOTE : loop_q;
    assign remote = (mode == `T1L_LOOP_REMOTE) || (mode == `T1L_LOOP_DUAL);
    assign digital = (mode == `T1L_LOOP_DIGITAL) || (mode == `T1L_LOOP_DUAL);
    assign analog = (mode == `T1L_LOOP_ANALOG);
    assign src_bit = remote ? rx_d_s : tx_data;
    assign src_stb = remote ? rx_stb : tx_bit_stb;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            drv_en_q <= 1'b0;
            loop_q <= 3'h0;
            pos_q <= 1'b0;
            neg_q <= 1'b0;
            alt_q <= 1'b0;
            rx_q <= 1'b0;
            rx_stb_q <= 1'b0;
        end else if (ce) begin
            drv_en_q <= ctl2_q[`T1L_DRIVER_ENABLE_PIN_BIT] && pin_en_s;
            loop_q <= ctl2_q[`T1L_LOOP_MSB:`T1L_LOOP_LSB];
            // Alternate mark inversion on the line pair
            if (src_stb) begin
                pos_q <= src_bit && !alt_q;
                neg_q <= src_bit && alt_q;
                alt_q <= alt_q ^ src_bit;
            end
            rx_stb_q <= digital ? tx_bit_stb : analog ? src_stb : rx_stb;
            rx_q <= digital ? tx_data : analog ? src_bit : rx_d_s;
        end
    end

    assign line_tx_positive = pos_q;
    assign line_tx_negative = neg_q;
    assign line_tx_positive_oe_n = !drv_en_q;
    assign line_tx_negative_oe_n = !drv_en_q;
    assign rx_data = rx_q;
    assign rx_bit_stb = rx_stb_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    drv_on_a: assert property (ce && ctl2_q[`T1L_DRIVER_ENABLE_PIN_BIT] && pin_en_s |=> !line_tx_positive_oe_n)
        else $error("driver not enabled");
    drv_off_a: assert property (ce && !ctl2_q[`T1L_DRIVER_ENABLE_PIN_BIT] |=> line_tx_positive_oe_n && line_tx_negative_oe_n)
        else $error("driver not released");
    pin_gate_a: assert property (ce && !pin_en_s |=> line_tx_negative_oe_n)
        else $error("driver on with pin low");
    no_loop_a: assert property (!loop_q[2] && st_q != T1L_ST_AUTO_LOOP |-> !remote && !digital && !analog)
        else $error("loop-back with msb clear");
    det_off_a: assert property (ce && nlcde_q == `T1L_DET_OFF |=> st_q == T1L_ST_OFF && cnt_q == '0)
        else $error("detection not off");
    up_only_a: assert property (st_q == T1L_ST_UP |-> !want_down)
        else $error("up mode watching down code");
    down_watch_a: assert property (ce && nlcde_q == `T1L_DET_DOWN |=> want_down)
        else $error("down mode not watching down code");
    auto_remote_a: assert property (ce && hit && st_q == T1L_ST_AUTO_UP && nlcde_q == `T1L_DET_AUTO
        |=> remote && flag_q)
        else $error("auto remote loop-back missing");
    flag_set_a: assert property (ce && flag_set |=> flag_q ##1 (flag_q || $past(flag_clr)))
        else $error("flag not set");
    sync_stage_a: assert property (ce ##1 ce |-> loop_q == $past(ctl2_q[`T1L_LOOP_MSB:`T1L_LOOP_LSB]))
        else $error("select not retimed");

    auto_loop_c: cover property (st_q == T1L_ST_AUTO_UP ##1 st_q == T1L_ST_AUTO_LOOP);
    flag_clr_c: cover property (flag_q ##1 !flag_q);
    drive_c: cover property (!line_tx_positive_oe_n && line_tx_positive);
endmodule : t1l_line_ctrl

/* t1l_far_end.sv */
module t1l_far_end (
    input wire logic mclk,
    output logic rx_line_clk,
    output logic rx_line_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_line_clk = 1'b0;
        rx_line_data = 1'b0;
    end
    // --------------------------------------------------------
    // Line bits, eight clocks each, clock still between frames
    // --------------------------------------------------------
    task automatic send(input logic [4:0] pat, input int per, input int nbits);
        int i;
        for (i = 0; i < nbits; i++) begin
            @(posedge mclk);
            rx_line_data <= pat[per-1-(i%per)];
            repeat (3) @(posedge mclk);
            rx_line_clk <= 1'b1;
            repeat (4) @(posedge mclk);
            rx_line_clk <= 1'b0;
        end
        // Released line: never leave the last bit standing
        @(posedge mclk);
        rx_line_data <= ~rx_line_data;
    endtask : send
endmodule : t1l_far_end

/* test_t1_line_driver_loopback_ctrl.sv */
`include "t1l_defines.svh"
module test_t1_line_driver_loopback_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A2 = 32'(`T1L_IDX_CTL_TWO) * 4;
    localparam logic [31:0] A3 = 32'(`T1L_IDX_CTL_THREE) * 4;
    localparam logic [31:0] AS = 32'(`T1L_IDX_STATUS) * 4;
    logic mclk = 0, sys_rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic drv_pin = 0, tx_data = 0, tx_bit_stb = 0, pready, pslverr, err, s, d, p1, n1;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic rx_line_data, rx_line_clk, pos, pos_oe_n, neg, neg_oe_n, rx_data, rx_bit_stb, flag;
    int err_total = 0, checks_done = 0, hits = 0, h0;
    always #2 mclk = ~mclk;
    always @(posedge mclk) if (pos | neg) hits <= hits + 1;
    t1l_line_ctrl #(.DETECT_BITS(20), .CNT_W(23)) dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .driver_enable_pin(drv_pin), .rx_line_data(rx_line_data),
        .rx_line_clk(rx_line_clk), .tx_data(tx_data), .tx_bit_stb(tx_bit_stb), .line_tx_positive(pos),
        .line_tx_positive_oe_n(pos_oe_n), .line_tx_negative(neg), .line_tx_negative_oe_n(neg_oe_n),
        .rx_data(rx_data), .rx_bit_stb(rx_bit_stb), .loop_code_detected_flag(flag));
    t1l_far_end far (.mclk(mclk), .rx_line_clk(rx_line_clk), .rx_line_data(rx_line_data));
    // --------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        int n;
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task rdc(input logic [31:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask : rdc
    task pin(input logic v);
        @(posedge mclk);
        drv_pin <= v;
        repeat (6) @(posedge mclk);
        #1;
    endtask : pin
    task wait_flag(input logic exp);
        int n;
        for (n = 0; n < 100 && flag !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        if (exp && flag !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
        chk(flag, exp);
    endtask : wait_flag
    task txb(input logic b);
        int i;
        s = 0;
        d = 0;
        @(posedge mclk);
        tx_data <= b;
        tx_bit_stb <= 1;
        @(posedge mclk);
        tx_bit_stb <= 0;
        // Strobe stands one cycle from the edge that drops tx_bit_stb
        for (i = 0; i < 4; i++) begin
            #1;
            if (rx_bit_stb === 1'b1) begin
                s = 1;
                d = rx_data;
            end
            @(posedge mclk);
        end
    endtask : txb
    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task t_regs;
        rdc(A2, 0);
        rdc(A3, 0);
        chk({pos_oe_n, neg_oe_n}, 2'b11);
        apb(1, A2, 32'hffffffff);
        rdc(A2, 32'hf);
        apb(1, A3, 32'hffffffff);
        rdc(A3, 32'hc0);
        apb(1, A2, 0);
        apb(1, A3, 0);
        apb(1, 32'h3c10, 32'hffffffff);
        chk(err, 1);
        apb(0, 32'h3c10, 0);
        chk({err, rd}, {1'b1, 32'h0});
        $display("test regs done");
    endtask : t_regs
    task t_driver;
        pin(1);
        apb(1, A2, 32'h8);
        pin(1);
        chk({pos_oe_n, neg_oe_n}, 2'b00);
        txb(1);
        p1 = pos;
        n1 = neg;
        chk(p1 ^ n1, 1);
        txb(1);
        chk({pos, neg}, {p1, n1} ^ 2'b11);
        txb(0);
        chk({pos, neg}, 2'b00);
        pin(0);
        chk({pos_oe_n, neg_oe_n}, 2'b11);
        pin(1);
        apb(1, A2, 0);
        pin(1);
        chk({pos_oe_n, neg_oe_n}, 2'b11);
        $display("test driver done");
    endtask : t_driver
    task t_loop;
        apb(1, A2, 32'h3);
        txb(1);
        chk(s, 0);
        apb(1, A2, 32'h7);
        txb(1);
        chk({s, d}, 2'b11);
        txb(0);
        chk({s, d}, 2'b10);
        apb(1, A2, 32'h4);
        txb(1);
        chk({s, d}, 2'b11);
        apb(1, A2, 32'h5);
        txb(1);
        chk({s, d}, 2'b11);
        // Line pair back to zero so only looped bits can raise it
        txb(0);
        apb(1, A2, 32'he);
        h0 = hits;
        far.send(5'h1f, 1, 6);
        chk(hits > h0, 1);
        far.send(5'h00, 1, 3);
        apb(1, A2, 0);
        $display("test loop done");
    endtask : t_loop
    task t_detect;
        far.send(5'h01, 5, 30);
        wait_flag(0);
        apb(1, A3, 32'h40);
        far.send(5'h01, 5, 30);
        wait_flag(1);
        rdc(AS, 32'h8);
        apb(1, AS, 32'h8);
        rdc(AS, 0);
        apb(1, A3, 32'h80);
        far.send(5'h01, 3, 30);
        wait_flag(1);
        apb(1, AS, 32'h8);
        apb(1, A3, 32'hc0);
        apb(1, A2, 32'h8);
        far.send(5'h01, 5, 30);
        wait_flag(1);
        far.send(5'h00, 1, 3);
        h0 = hits;
        far.send(5'h1f, 1, 6);
        chk(hits > h0, 1);
        far.send(5'h00, 1, 3);
        apb(1, A3, 0);
        h0 = hits;
        far.send(5'h1f, 1, 6);
        chk(hits, h0);
        $display("test detect done");
    endtask : t_detect
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 0;
        t_regs();
        t_driver();
        t_loop();
        t_detect();
        report_and_stop();
    end
endmodule : test_t1_line_driver_loopback_ctrl
